// ===== hdl/cps_mon_if.sv
// Interface between the main controller and the over-pressure monitor
`timescale 1ns/1ps
interface cps_mon_if;
    logic [2:0] measure_type_sel;
    logic [2:0] monitor_ack_state;
    logic actuator_supply_en_n;
    modport ctrl (output measure_type_sel, input monitor_ack_state, input actuator_supply_en_n);
    modport mon (input measure_type_sel, output monitor_ack_state, output actuator_supply_en_n);
endinterface

// ===== hdl/cps_monitor.sv
// Redundant over-pressure monitor with latched emergency shutdown
`timescale 1ns/1ps
module cps_monitor
    import cps_pkg::*;
#(
    parameter int SAMPLE_CYC = CPS_SAMPLE_CYC
) (
    input wire logic clock,
    input wire logic por_n,
    input wire logic [11:0] overpress_sense,
    input wire logic [11:0] ref_two_point_five,
    input wire logic [15:0] overpress_limit_raw,
    cps_mon_if.mon mon
);
    typedef struct packed {
        logic [17:0] div;
        logic shutdown;
        logic [2:0] ack;
    } cps_mon_s;
    cps_mon_s st_reg, st_next;

    // Limit of the acknowledged type, in mmHg
    function automatic logic [15:0] cps_limit(input logic [2:0] t);
        case (t)
            CPS_TYPE_ADULT: cps_limit = CPS_LIMIT_ADULT;
            CPS_TYPE_PED: cps_limit = CPS_LIMIT_PED;
            CPS_TYPE_NEO: cps_limit = CPS_LIMIT_NEO;
            default: cps_limit = CPS_LIMIT_NEO;
        endcase
    endfunction

    // Sample tick, limit check and sticky shutdown; no sleep state exists
    always_comb begin
        st_next = st_reg;
        if (st_reg.div == 18'(SAMPLE_CYC - 1)) begin
            st_next.div = '0;
            if ({4'h0, overpress_sense} > cps_limit(st_reg.ack) || ref_two_point_five == CPS_ADC_FULL ||
                overpress_limit_raw > CPS_LIMIT_ADULT) begin
                st_next.shutdown = 1'b1;
            end
        end else begin
            st_next.div = st_reg.div + 18'h00001;
        end
        // Acknowledge type only while healthy
        st_next.ack = st_next.shutdown ? CPS_TYPE_NONE : mon.measure_type_sel;
    end

    // Only power-on reset clears shutdown; the controller reset is not wired here
    always_ff @(posedge clock or negedge por_n) begin
        if (!por_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign mon.monitor_ack_state = st_reg.ack;
    assign mon.actuator_supply_en_n = st_reg.shutdown;
endmodule

// ===== hdl/cps_pkg.sv
// Package of constants and types for the cuff pressure safety control block
package cps_pkg;
    // Pressure limits per mode, in mmHg
    localparam logic [15:0] CPS_LIMIT_ADULT = 16'h0127; // 295
    localparam logic [15:0] CPS_LIMIT_PED = 16'h00C3; // 195
    localparam logic [15:0] CPS_LIMIT_NEO = 16'h0091; // 145
    // Measurement type codes on the mode bus
    localparam logic [2:0] CPS_TYPE_NONE = 3'h0;
    localparam logic [2:0] CPS_TYPE_ADULT = 3'h1;
    localparam logic [2:0] CPS_TYPE_PED = 3'h2;
    localparam logic [2:0] CPS_TYPE_NEO = 3'h3;
    localparam int CPS_DAC_W = 12;
    localparam logic [11:0] CPS_DAC_OFF = 12'h000;
    localparam logic [11:0] CPS_DAC_FULL = 12'hFFF;
    localparam logic [11:0] CPS_DAC_STEP = 12'h001;
    localparam logic [11:0] CPS_DAC_NEO_PUMP = 12'h800;
    // Bleed rate target in mmHg per second
    localparam int CPS_BLEED_RATE = 6;
    localparam int CPS_CLK_HZ = 200000000;
    localparam int CPS_SAMPLE_MHZ_X1000 = 1196; // 1.196 kHz sample rate, in Hz
    localparam int CPS_SAMPLE_CYC = CPS_CLK_HZ / CPS_SAMPLE_MHZ_X1000;
    localparam int CPS_BLEED_CYC = CPS_CLK_HZ / CPS_BLEED_RATE;
    localparam logic [11:0] CPS_ADC_FULL = 12'hFFF;
    localparam int CPS_PWM_W = 8;
    typedef enum logic [2:0] {CPS_IDLE, CPS_WAIT_ACK, CPS_INFLATE, CPS_BLEED, CPS_DUMP} cps_phase_e;
endpackage

// ===== hdl/cps_top.sv
// Main cuff controller with actuator drives and the redundant monitor
`timescale 1ns/1ps
// How it works
// - Over the mode limit, halt and open dump and bleed valves.
// - Monitor cuts actuator supply on uncorrected over-pressure, independent of controller.
// - Shutdown stays latched until power cycle.
// - Pump driven by active-high PWM output.
// - Dump valve drive high keeps the valve closed.
// - Bleed valve set by 12-bit code; zero open, full scale closed.
// - During measurement bleed is regulated for 6 mmHg per second fall.
// - Neonate mode may throttle inflation with the bleed valve.
// - After reset pump off and both valves open.
// - Controller sends type on 3 bits; monitor returns matching state.
// - Monitor samples backup pressure at 1.196 kHz, shuts down on fault.
// - Shutdown drives actuator supply enable high.
// - Controller reset never releases the monitor.
// - Full-scale reference reading means converter reference failed.
// - Monitor never sleeps.
// - Controller watches pressures, reference and supplies.
// - Host reset holds only the controller in reset.
module cps_top
    import cps_pkg::*;
#(
    parameter int SAMPLE_CYC = CPS_SAMPLE_CYC,
    parameter int BLEED_CYC = CPS_BLEED_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic host_module_reset_n,
    input wire logic start,
    input wire logic [2:0] measure_type,
    input wire logic measure_done,
    input wire logic [15:0] cuff_pressure,
    input wire logic [15:0] overpress_pressure,
    input wire logic [15:0] target_pressure,
    input wire logic [11:0] overpress_sense,
    input wire logic [11:0] ref_two_point_five,
    input wire logic [11:0] analog_five_supply,
    input wire logic [11:0] supply_twelve,
    input wire logic [11:0] switched_actuator_supply,
    input wire logic [7:0] pump_duty,
    output logic pump_drive,
    output logic dump_valve_drive,
    output logic [11:0] bleed_valve,
    output logic [2:0] measure_type_sel,
    output logic actuator_supply_en_n,
    output logic overpress_halt,
    output logic monitor_not_ready,
    output logic supply_fault,
    output logic measuring
);
    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] por_sync;
    logic [1:0] ctl_sync;
    logic por_n;
    logic ctl_n;

    // Power-on reset reaches the monitor; host reset only the controller
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            por_sync <= 2'b00;
        end else begin
            por_sync <= {por_sync[0], 1'b1};
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctl_sync <= 2'b00;
        end else if (!host_module_reset_n) begin
            ctl_sync <= 2'b00;
        end else begin
            ctl_sync <= {ctl_sync[0], 1'b1};
        end
    end
    assign por_n = por_sync[1];
    assign ctl_n = ctl_sync[1];

    // ****************************************
    // Monitor
    // ****************************************
    cps_mon_if mif();
    cps_monitor #(.SAMPLE_CYC(SAMPLE_CYC)) u_mon (
        .clock(clock),
        .por_n(por_n),
        .overpress_sense(overpress_sense),
        .ref_two_point_five(ref_two_point_five),
        .overpress_limit_raw(overpress_pressure),
        .mon(mif.mon)
    );

    // ****************************************
    // Main controller state
    // ****************************************
    typedef struct packed {
        cps_phase_e phase;
        logic [2:0] type_sel;
        logic [7:0] pwm_cnt;
        logic pump;
        logic dump;
        logic [11:0] dac;
        logic [31:0] tick;
        logic [15:0] last_p;
        logic halt;
        logic not_ready;
        logic sfault;
        logic meas;
        logic supply_off;
    } cps_ctl_s;
    cps_ctl_s c_reg, c_next;

    function automatic logic [15:0] cps_mode_limit(input logic [2:0] t);
        case (t)
            CPS_TYPE_ADULT: cps_mode_limit = CPS_LIMIT_ADULT;
            CPS_TYPE_PED: cps_mode_limit = CPS_LIMIT_PED;
            default: cps_mode_limit = CPS_LIMIT_NEO;
        endcase
    endfunction

    // Sequencer, actuator drives and supervision
    always_comb begin
        c_next = c_reg;
        c_next.pwm_cnt = c_reg.pwm_cnt + 8'h01;
        c_next.supply_off = mif.actuator_supply_en_n;
        // Supervision of reference and supplies; a dead rail reads zero
        c_next.sfault = (ref_two_point_five == CPS_ADC_FULL) || (analog_five_supply == 12'h000) ||
            (supply_twelve == 12'h000) ||
            (switched_actuator_supply == 12'h000 && !mif.actuator_supply_en_n);
        c_next.not_ready = (mif.monitor_ack_state != c_reg.type_sel);
        c_next.pump = 1'b0;
        case (c_reg.phase)
            CPS_IDLE: begin
                c_next.dump = 1'b0;
                c_next.dac = CPS_DAC_OFF;
                c_next.meas = 1'b0;
                if (start) begin
                    c_next.type_sel = measure_type;
                    c_next.halt = 1'b0;
                    c_next.phase = CPS_WAIT_ACK;
                end
            end
            CPS_WAIT_ACK: begin
                if (mif.monitor_ack_state == c_reg.type_sel && c_reg.type_sel != CPS_TYPE_NONE) begin
                    c_next.phase = CPS_INFLATE;
                end
            end
            CPS_INFLATE: begin
                c_next.dump = 1'b1;
                c_next.dac = (c_reg.type_sel == CPS_TYPE_NEO) ? CPS_DAC_NEO_PUMP : CPS_DAC_FULL;
                c_next.pump = (c_reg.pwm_cnt < pump_duty);
                if (cuff_pressure >= target_pressure) begin
                    c_next.phase = CPS_BLEED;
                    c_next.tick = '0;
                    c_next.last_p = cuff_pressure;
                    c_next.meas = 1'b1;
                end
            end
            CPS_BLEED: begin
                c_next.dump = 1'b1;
                c_next.tick = c_reg.tick + 32'h1;
                // Once per sixth of a second expect a 1 mmHg drop
                if (c_reg.tick >= 32'(BLEED_CYC - 1)) begin
                    c_next.tick = '0;
                    c_next.last_p = cuff_pressure;
                    if (c_reg.last_p > cuff_pressure + 16'h0001 && c_reg.dac != CPS_DAC_FULL) begin
                        c_next.dac = c_reg.dac + CPS_DAC_STEP;
                    end else if (c_reg.last_p <= cuff_pressure && c_reg.dac != CPS_DAC_OFF) begin
                        c_next.dac = c_reg.dac - CPS_DAC_STEP;
                    end
                end
                if (measure_done) begin
                    c_next.phase = CPS_DUMP;
                end
            end
            CPS_DUMP: begin
                c_next.dump = 1'b0;
                c_next.dac = CPS_DAC_OFF;
                c_next.meas = 1'b0;
                c_next.phase = CPS_IDLE;
            end
            default: c_next.phase = CPS_IDLE;
        endcase
        // Mismatch after inflation began means the monitor dropped out
        if ((c_reg.phase == CPS_INFLATE || c_reg.phase == CPS_BLEED) &&
            mif.monitor_ack_state != c_reg.type_sel) begin
            c_next.phase = CPS_DUMP;
            c_next.pump = 1'b0;
            c_next.dump = 1'b0;
            c_next.dac = CPS_DAC_OFF;
        end
        // Pressure limit overrides everything
        if (c_reg.phase != CPS_IDLE && cuff_pressure > cps_mode_limit(c_reg.type_sel)) begin
            c_next.halt = 1'b1;
            c_next.phase = CPS_DUMP;
            c_next.pump = 1'b0;
            c_next.dump = 1'b0;
            c_next.dac = CPS_DAC_OFF;
        end
    end

    // Controller state, cleared by power-on or host reset
    always_ff @(posedge clock or negedge ctl_n) begin
        if (!ctl_n) begin
            c_reg <= '0;
            c_reg.phase <= CPS_IDLE;
        end else begin
            c_reg <= c_next;
        end
    end

    // Output flops; drives are forced open while supply is cut
    always_ff @(posedge clock or negedge por_n) begin
        if (!por_n) begin
            pump_drive <= 1'b0;
            dump_valve_drive <= 1'b0;
            bleed_valve <= CPS_DAC_OFF;
            measure_type_sel <= CPS_TYPE_NONE;
            actuator_supply_en_n <= 1'b0;
            overpress_halt <= 1'b0;
            monitor_not_ready <= 1'b0;
            supply_fault <= 1'b0;
            measuring <= 1'b0;
        end else begin
            pump_drive <= ctl_n & c_reg.pump & ~c_reg.supply_off;
            dump_valve_drive <= ctl_n & c_reg.dump & ~c_reg.supply_off;
            bleed_valve <= (ctl_n && !c_reg.supply_off) ? c_reg.dac : CPS_DAC_OFF;
            measure_type_sel <= c_reg.type_sel;
            actuator_supply_en_n <= mif.actuator_supply_en_n;
            overpress_halt <= c_reg.halt;
            monitor_not_ready <= c_reg.not_ready;
            supply_fault <= c_reg.sfault;
            measuring <= c_reg.meas;
        end
    end
    assign mif.measure_type_sel = c_reg.type_sel;
endmodule

// ===== verification/cps_chk.sv
// Assertion checker for the cuff pressure safety control block
`timescale 1ns/1ps
module cps_chk
    import cps_pkg::*;
#(
    parameter int SAMPLE_CYC = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic host_module_reset_n,
    input wire logic [15:0] cuff_pressure,
    input wire logic [11:0] overpress_sense,
    input wire logic [11:0] ref_two_point_five,
    input wire logic pump_drive,
    input wire logic dump_valve_drive,
    input wire logic [11:0] bleed_valve,
    input wire logic [2:0] measure_type_sel,
    input wire logic actuator_supply_en_n,
    input wire logic overpress_halt
);
    // Trip bound: a full sample period plus the shutdown pipeline
    localparam int TRIP = SAMPLE_CYC + 4;
    logic [15:0] lim;
    logic drives_off;
    // Limit of the requested mode and the all-actuators-off condition
    assign lim = (measure_type_sel == CPS_TYPE_ADULT) ? CPS_LIMIT_ADULT :
                 (measure_type_sel == CPS_TYPE_PED) ? CPS_LIMIT_PED : CPS_LIMIT_NEO;
    assign drives_off = !pump_drive && !dump_valve_drive && (bleed_valve == CPS_DAC_OFF);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // ****************************************
    // Assertions
    // ****************************************
    limit_halt_a: assert property (dump_valve_drive && measure_type_sel != CPS_TYPE_NONE && cuff_pressure > lim
        |-> ##[1:3] overpress_halt && !dump_valve_drive) else $error("over-limit did not halt");
    halt_opens_a: assert property (overpress_halt |-> drives_off) else $error("halt with actuator on");
    shutdown_sticky_a: assert property (actuator_supply_en_n |=> actuator_supply_en_n)
        else $error("shutdown released");
    shutdown_cuts_a: assert property (actuator_supply_en_n [*3] |-> drives_off)
        else $error("drives on in shutdown");
    sense_trip_a: assert property (overpress_sense > CPS_LIMIT_ADULT[11:0] |-> ##[1:TRIP] actuator_supply_en_n)
        else $error("backup sense did not trip");
    ref_trip_a: assert property (ref_two_point_five == CPS_ADC_FULL |-> ##[1:TRIP] actuator_supply_en_n)
        else $error("reference failure did not trip");
    none_idle_a: assert property (measure_type_sel == CPS_TYPE_NONE |-> !dump_valve_drive && !pump_drive)
        else $error("inflating without type");
    reset_safe_a: assert property ($rose(nrst) |-> drives_off) else $error("actuators on out of reset");
    host_reset_a: assert property (!host_module_reset_n [*3] |-> drives_off && measure_type_sel == 3'h0)
        else $error("controller active in host reset");
    // Main scenarios reached
    cover property ($rose(actuator_supply_en_n));
    cover property ($rose(overpress_halt));
    cover property ($rose(pump_drive));
endmodule
bind cps_top cps_chk #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.clock, .nrst, .host_module_reset_n, .cuff_pressure,
    .overpress_sense, .ref_two_point_five, .pump_drive, .dump_valve_drive, .bleed_valve, .measure_type_sel,
    .actuator_supply_en_n, .overpress_halt);

// ===== verification/cps_host_model.sv
// Host side model: measurement requests and the host reset line
`timescale 1ns/1ps
module cps_host_model (
    input wire logic clock,
    input wire logic req,
    input wire logic [2:0] req_type,
    input wire logic hold_rst,
    output logic start = 1'b0,
    output logic [2:0] measure_type = 3'h0,
    output logic host_module_reset_n = 1'b1
);
    // Take the request at the edge, launch it just after; no race with the bench
    always @(posedge clock) begin
        start <= #1 req;
        measure_type <= #1 req_type;
        host_module_reset_n <= #1 !hold_rst;
    end
endmodule

// ===== verification/cps_top_tb_top.sv
// Self-checking testbench for the cuff pressure safety control block
`timescale 1ns/1ps
module cps_top_tb_top;
    import cps_pkg::*;
    localparam int SC = 8;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic req = 1'b0;
    logic hold_rst = 1'b0;
    logic measure_done = 1'b0;
    logic [2:0] req_type = 3'h0;
    logic [15:0] cuff_pressure = 16'h0010;
    logic [15:0] overpress_pressure = 16'h0010;
    logic [15:0] target_pressure = 16'h0100;
    logic [11:0] overpress_sense = 12'h010;
    logic [11:0] ref_two_point_five = 12'h800;
    logic [11:0] analog_five_supply = 12'h800;
    logic [11:0] supply_twelve = 12'h800;
    logic [11:0] switched_actuator_supply = 12'h800;
    logic [7:0] pump_duty = 8'h80;
    logic start, host_module_reset_n, pump_drive, dump_valve_drive, actuator_supply_en_n;
    logic overpress_halt, monitor_not_ready, supply_fault, measuring;
    logic [2:0] measure_type, measure_type_sel;
    logic [11:0] bleed_valve;
    logic [15:0] lims [1:3] = '{CPS_LIMIT_ADULT, CPS_LIMIT_PED, CPS_LIMIT_NEO};
    int n_mismatch = 0;
    int cmp_count = 0;
    int n;
    cps_host_model host (.clock, .req, .req_type, .hold_rst, .start, .measure_type, .host_module_reset_n);
    cps_top #(.SAMPLE_CYC(SC), .BLEED_CYC(16)) DUT (.clock, .nrst, .host_module_reset_n, .start, .measure_type,
        .measure_done, .cuff_pressure, .overpress_pressure, .target_pressure, .overpress_sense, .ref_two_point_five,
        .analog_five_supply, .supply_twelve, .switched_actuator_supply, .pump_duty, .pump_drive, .dump_valve_drive,
        .bleed_valve, .measure_type_sel, .actuator_supply_en_n, .overpress_halt, .monitor_not_ready,
        .supply_fault, .measuring);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request a cycle, then wait bounded for the dump valve to close
    task automatic go(input logic [2:0] t);
        int i;
        req_type = t;
        req = 1'b1;
        tick(2);
        req = 1'b0;
        for (i = 0; i < 40 && dump_valve_drive !== 1'b1; i++) tick(1);
    endtask
    // Host reset long enough to pass the two-stage synchroniser
    task automatic host_rst();
        hold_rst = 1'b1;
        tick(6);
        check(16'(dump_valve_drive), 16'h0);
        hold_rst = 1'b0;
        tick(6);
    endtask
    task automatic power_cycle();
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(3);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Clock, 5 ns period
    initial forever #2.5 clock = ~clock;
    // Watchdog sized well above the expected run of about a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tick(20);
        nrst = 1'b1;
        tick(3);
        check(16'({pump_drive, dump_valve_drive, bleed_valve, actuator_supply_en_n}), 16'h0);
        go(CPS_TYPE_NONE);
        tick(20);
        check(16'({pump_drive, dump_valve_drive}), 16'h0);
        host_rst();
        $display("test reset and no-type done");
        // Each mode: handshake, drives, PWM share, limit boundary
        for (int t = 1; t <= 3; t++) begin
            go(3'(t));
            check(16'(measure_type_sel), 16'(t));
            check(16'(dump_valve_drive), 16'h1);
            check(16'(monitor_not_ready), 16'h0);
            if (t == 3) check(16'(bleed_valve), 16'(CPS_DAC_NEO_PUMP));
            n = 0;
            for (int k = 0; k < 256; k++) begin
                tick(1);
                n += int'(pump_drive);
            end
            check(16'(n), 16'(pump_duty));
            cuff_pressure = lims[t];
            tick(4);
            check(16'(overpress_halt), 16'h0);
            // Adult sits at target in bleed: a flat pressure must open the bleed one step
            if (t == 1) begin
                tick(20);
                check(16'({3'h0, measuring, bleed_valve}), 16'({3'h0, 1'b1, CPS_DAC_FULL - CPS_DAC_STEP}));
                measure_done = 1'b1;
                tick(3);
                measure_done = 1'b0;
                check(16'({measuring, dump_valve_drive}), 16'h0);
                go(3'(t));
            end
            cuff_pressure = lims[t] + 16'h0001;
            tick(3);
            check(16'({overpress_halt, pump_drive, dump_valve_drive, bleed_valve}), 16'h4000);
            cuff_pressure = 16'h0010;
            host_rst();
        end
        $display("test modes done");
        go(CPS_TYPE_ADULT);
        overpress_sense = 12'h200;
        tick(SC + 4);
        check(16'({actuator_supply_en_n, pump_drive, dump_valve_drive, bleed_valve}), 16'h4000);
        check(16'(monitor_not_ready), 16'h1);
        overpress_sense = 12'h010;
        host_rst();
        check(16'(actuator_supply_en_n), 16'h1);
        power_cycle();
        check(16'(actuator_supply_en_n), 16'h0);
        ref_two_point_five = 12'hFFF;
        tick(SC + 4);
        check(16'({actuator_supply_en_n, supply_fault}), 16'h3);
        ref_two_point_five = 12'h800;
        power_cycle();
        analog_five_supply = 12'h000;
        tick(4);
        check(16'(supply_fault), 16'h1);
        // Backup pressure channel above the adult ceiling trips the monitor
        power_cycle();
        overpress_pressure = CPS_LIMIT_ADULT + 16'h0001;
        tick(SC + 4);
        check(16'(actuator_supply_en_n), 16'h1);
        $display("test shutdown and supplies done");
        results();
    end
endmodule
